// [core/octal_sar_conversion_sequencer.v]
// Conversion sequencer of an eight-channel simultaneous-sampling SAR core.
// Assumes APB master on pclk; comparator and strobe synchronous to pclk.
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "sar_seq_map.vh"

module octal_sar_conversion_sequencer #(
   parameter CH = `CHANNELS,
   parameter W = `CODE_BITS,
   parameter CONV_DIV = `CONV_DIV
) (
   // APB slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Conversion control and analog core
   input wire convert_strobe,
   input wire comparator_high,
   input wire lvds_mode,
   output reg [CH-1:0] sample_track_q,
   output reg [W-1:0] charge_redistribution_dac_q,
   output reg [2:0] dac_channel_q,
   output reg dac_active_q,
   output reg core_power_down_q,
   // Readout side
   output reg [3:0] output_lanes_q,
   output reg results_ready_q,
   output reg busy_q
);

   localparam ST_ACQUIRE = 2'd0;
   localparam ST_CONVERT = 2'd1;
   localparam ST_PREPARE = 2'd2;

   localparam [2:0] LAST_CH = 3'd7;

   // Register state
   reg [31:0] control_q;
   reg [`SPAN_WORD_BITS-1:0] span_cfg_q;
   reg [`SPAN_WORD_BITS-1:0] span_act_q;
   reg [31:0] conv_count_q;
   reg done_q;
   reg [W-1:0] raw_q [0:CH-1];
   reg [W-1:0] result_q [0:CH-1];

   // Sequencer state
   reg [1:0] state_q;
   reg [2:0] ch_q;
   reg strobe_prev_q;
   reg sar_start_q;
   reg [7:0] div_q;
   reg step_en_q;

   wire [W-1:0] sar_trial;
   wire sar_busy;
   wire sar_done;
   wire [W-1:0] coded;

   reg [31:0] rd_data;
   reg rd_hit;
   reg [3:0] next_ch;
   reg [3:0] first_ch;
   integer i;

   wire apb_access = psel && penable && pready;
   wire wr_en = apb_access && pwrite;
   wire strobe_rise = convert_strobe && !strobe_prev_q;
   wire power_down = control_q[`CTL_POWER_DOWN];

   function [`SPAN_BITS-1:0] span_of;
      input [`SPAN_WORD_BITS-1:0] word;
      input [2:0] ch;
      begin
         span_of = word[ch*`SPAN_BITS +: `SPAN_BITS];
      end
   endfunction

   function ch_enabled;
      input [`SPAN_WORD_BITS-1:0] word;
      input [2:0] ch;
      begin
         ch_enabled = (span_of(word, ch) != `SPAN_DISABLED);
      end
   endfunction

   // First enabled channel at or after the given one; 8 means none left
   function [3:0] find_next;
      input [`SPAN_WORD_BITS-1:0] word;
      input [3:0] from;
      integer k;
      begin
         find_next = 4'd8;
         for (k = CH - 1; k >= 0; k = k - 1) begin
            if (k >= from && ch_enabled(word, k[2:0])) begin
               find_next = k[3:0];
            end
         end
      end
   endfunction

   // Internal conversion clock as an enable pulse
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 8'h00;
         step_en_q <= 1'b0;
      end else if (state_q != ST_CONVERT) begin
         div_q <= 8'h00;
         step_en_q <= 1'b0;
      end else if (div_q == CONV_DIV[7:0] - 8'h01) begin
         div_q <= 8'h00;
         step_en_q <= 1'b1;
      end else begin
         div_q <= div_q + 8'h01;
         step_en_q <= 1'b0;
      end
   end

   sar_search #(
      .W(W)
   ) u_search (
      .clk(pclk),
      .rst_n(presetn),
      .start(sar_start_q),
      .step_en(step_en_q),
      .cmp_high(comparator_high),
      .trial_q(sar_trial),
      .busy_q(sar_busy),
      .done_q(sar_done)
   );

   output_coder #(
      .W(W)
   ) u_coder (
      .span(span_of(span_act_q, ch_q)),
      .raw(raw_q[ch_q]),
      .code(coded)
   );

   always @* begin
      next_ch = find_next(span_act_q, {1'b0, ch_q} + 4'd1);
      first_ch = find_next(span_cfg_q, 4'd0);
   end

   // Conversion sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_ACQUIRE;
         ch_q <= 3'd0;
         strobe_prev_q <= 1'b0;
         sar_start_q <= 1'b0;
         span_act_q <= `SPAN_RESET;
         conv_count_q <= 32'h0000_0000;
         for (i = 0; i < CH; i = i + 1) begin
            raw_q[i] <= {W{1'b0}};
            result_q[i] <= {W{1'b0}};
         end
      end else begin
         strobe_prev_q <= convert_strobe;
         sar_start_q <= 1'b0;
         case (state_q)
            ST_ACQUIRE: begin
               // Strobe is ignored while powered down
               if (strobe_rise && !power_down) begin
                  span_act_q <= span_cfg_q;
                  conv_count_q <= conv_count_q + 32'h0000_0001;
                  if (first_ch == 4'd8) begin
                     ch_q <= 3'd0;
                     state_q <= ST_PREPARE;
                  end else begin
                     ch_q <= first_ch[2:0];
                     sar_start_q <= 1'b1;
                     state_q <= ST_CONVERT;
                  end
               end
            end
            ST_CONVERT: begin
               if (sar_done) begin
                  raw_q[ch_q] <= sar_trial;
                  if (next_ch == 4'd8) begin
                     ch_q <= 3'd0;
                     state_q <= ST_PREPARE;
                  end else begin
                     ch_q <= next_ch[2:0];
                     sar_start_q <= 1'b1;
                  end
               end
            end
            ST_PREPARE: begin
               // One channel coded per cycle; results change one at a time, channel 0 first
               result_q[ch_q] <= coded;
               if (ch_q == LAST_CH) begin
                  ch_q <= 3'd0;
                  state_q <= ST_ACQUIRE;
               end else begin
                  ch_q <= ch_q + 3'd1;
               end
            end
            default: begin
               state_q <= ST_ACQUIRE;
            end
         endcase
      end
   end

   // Analog core and readout-side outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_track_q <= {CH{1'b0}};
         charge_redistribution_dac_q <= {W{1'b0}};
         dac_channel_q <= 3'd0;
         dac_active_q <= 1'b0;
         core_power_down_q <= 1'b0;
         output_lanes_q <= 4'd1;
         results_ready_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         if (state_q == ST_ACQUIRE && !power_down &&
             !(strobe_rise)) begin
            sample_track_q <= {CH{1'b1}};
         end else begin
            sample_track_q <= {CH{1'b0}};
         end
         charge_redistribution_dac_q <= sar_trial;
         dac_channel_q <= ch_q;
         dac_active_q <= sar_busy;
         core_power_down_q <= power_down && state_q == ST_ACQUIRE;
         if (lvds_mode) begin
            output_lanes_q <= 4'd1;
         end else begin
            output_lanes_q <= {1'b0, control_q[`CTL_LANES_HI:`CTL_LANES_LO]}
                              + 4'd1;
         end
         results_ready_q <= state_q == ST_PREPARE && ch_q == LAST_CH;
         busy_q <= state_q != ST_ACQUIRE;
      end
   end

   // Read mux
   always @* begin
      rd_data = 32'h0000_0000;
      rd_hit = 1'b1;
      case (paddr)
         `OFS_CONTROL: rd_data = control_q;
         `OFS_SPAN_CFG: rd_data = {8'h00, span_cfg_q};
         `OFS_STATUS: begin
            rd_data[`ST_BUSY] = busy_q;
            rd_data[`ST_DONE] = done_q;
            rd_data[`ST_LVDS] = lvds_mode;
            rd_data[`ST_POWER_DOWN] = power_down;
            rd_data[`ST_LANES_HI:`ST_LANES_LO] = output_lanes_q;
         end
         `OFS_SPAN_ACTIVE: rd_data = {8'h00, span_act_q};
         `OFS_CONV_COUNT: rd_data = conv_count_q;
         default: begin
            if (paddr >= `OFS_RESULT_BASE && paddr <= `OFS_RESULT_LAST &&
                paddr[1:0] == 2'b00) begin
               rd_data = {{(32-W){1'b0}}, result_q[paddr[4:2]]};
            end else begin
               rd_hit = 1'b0;
            end
         end
      endcase
   end

   // APB slave: one wait state, ready one cycle after penable rises
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !rd_hit;
            prdata <= pwrite ? 32'h0000_0000 : rd_data;
         end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
         end
      end
   end

   // Software-written registers; done flag set wins over its clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_q <= `CTL_RESET;
         span_cfg_q <= `SPAN_RESET;
         done_q <= 1'b0;
      end else begin
         if (wr_en && paddr == `OFS_CONTROL) begin
            control_q <= {28'h000_0000, pwdata[3:0]};
         end
         if (wr_en && paddr == `OFS_SPAN_CFG) begin
            span_cfg_q <= pwdata[`SPAN_WORD_BITS-1:0];
         end
         if (state_q == ST_PREPARE && ch_q == LAST_CH) begin
            done_q <= 1'b1;
         end else if (wr_en && paddr == `OFS_STATUS && pwdata[`ST_DONE]) begin
            done_q <= 1'b0;
         end
      end
   end

endmodule

// [core/output_coder.v]
// Turns a raw offset-binary search result into the channel's output code.
// Assumes the raw code spans the channel's whole full-scale range.
`timescale 1ns/1ps
`include "sar_seq_map.vh"

module output_coder #(
   parameter W = `CODE_BITS
) (
   // Range and raw result
   input wire [`SPAN_BITS-1:0] span,
   input wire [W-1:0] raw,
   // Formatted code
   output reg [W-1:0] code
);

   // Ranges 7, 6, 3 and 2 are the bipolar ones
   function is_bipolar;
      input [`SPAN_BITS-1:0] s;
      begin
         is_bipolar = s[1];
      end
   endfunction

   always @* begin
      if (span == `SPAN_DISABLED) begin
         code = {W{1'b0}};
      end else if (is_bipolar(span)) begin
         code = {~raw[W-1], raw[W-2:0]};
      end else begin
         code = raw;
      end
   end

endmodule

// [core/sar_search.v]
// One successive approximation search over a binary-weighted charge DAC.
// Assumes the comparator input settles within one step_en period.
`timescale 1ns/1ps
`include "sar_seq_map.vh"

module sar_search #(
   parameter W = `CODE_BITS
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Control
   input wire start,
   input wire step_en,
   input wire cmp_high,
   // Search state
   output reg [W-1:0] trial_q,
   output reg busy_q,
   output reg done_q
);

   reg [W-1:0] mask_q;
   reg [W-1:0] kept;

   // Weight under test is dropped when the sample lies below the trial
   always @* begin
      kept = cmp_high ? trial_q : (trial_q & ~mask_q);
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trial_q <= {W{1'b0}};
         mask_q <= {W{1'b0}};
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (start) begin
            trial_q <= {1'b1, {(W-1){1'b0}}};
            mask_q <= {1'b1, {(W-1){1'b0}}};
            busy_q <= 1'b1;
         end else if (busy_q && step_en) begin
            if (mask_q[0]) begin
               trial_q <= kept;
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end else begin
               trial_q <= kept | (mask_q >> 1);
               mask_q <= mask_q >> 1;
            end
         end
      end
   end

endmodule

// [core/sar_seq_map.vh]
// Register map, field positions, reset values and timing of the sequencer.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef SAR_SEQ_MAP_VH
`define SAR_SEQ_MAP_VH

// Register byte offsets
`define OFS_CONTROL 12'h000
`define OFS_SPAN_CFG 12'h004
`define OFS_STATUS 12'h008
`define OFS_SPAN_ACTIVE 12'h00c
`define OFS_CONV_COUNT 12'h010
`define OFS_RESULT_BASE 12'h020
`define OFS_RESULT_LAST 12'h03c

// Control fields
`define CTL_POWER_DOWN 0
`define CTL_LANES_LO 1
`define CTL_LANES_HI 3
`define CTL_RESET 32'h0000_0000

// Status fields
`define ST_BUSY 0
`define ST_DONE 1
`define ST_LVDS 2
`define ST_POWER_DOWN 3
`define ST_LANES_LO 4
`define ST_LANES_HI 7

// Span configuration word, three bits per channel
`define SPAN_BITS 3
`define SPAN_WORD_BITS 24
`define SPAN_RESET 24'hff_ffff
`define SPAN_DISABLED 3'h0

// Conversion data
`define CODE_BITS 18
`define CHANNELS 8

// Internal conversion clock: pclk cycles per comparator decision
`define CONV_DIV 4

`endif

// [tb/analog_core_model.sv]
// Behavioural analog core: eight sample-and-hold stages and one comparator.
// Assumes the sequencer drives track, DAC trial and DAC channel on pclk.
`timescale 1ns/1ps
module analog_core_model (
   // Clock
   input wire pclk,
   // Analog inputs, 18 bits per channel
   input wire [143:0] sample_in,
   // From the sequencer
   input wire [7:0] sample_track_q,
   input wire [17:0] charge_redistribution_dac_q,
   input wire [2:0] dac_channel_q,
   output wire comparator_high
);
   reg [17:0] held [0:7];
   integer i;
   initial begin
      for (i = 0; i < 8; i = i + 1) held[i] = 18'h0_0000;
   end
   // Tracks while the switch is closed, freezes on hold
   always @(posedge pclk) begin
      for (i = 0; i < 8; i = i + 1)
         if (sample_track_q[i]) held[i] <= sample_in[18*i +: 18];
   end
   // Only the selected channel reaches the comparator
   assign comparator_high =
      held[dac_channel_q] >= charge_redistribution_dac_q;
endmodule

// [tb/sar_seq_checker.sv]
// Port-level assertions for the conversion sequencer.
// Assumes one clock domain, pclk, with presetn as async reset.
`timescale 1ns/1ps
module sar_seq_checker #(parameter W = 18) (
   // APB
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Conversion
   input wire convert_strobe,
   input wire lvds_mode,
   input wire [7:0] sample_track_q,
   input wire [W-1:0] charge_redistribution_dac_q,
   input wire dac_active_q,
   input wire core_power_down_q,
   input wire [3:0] output_lanes_q,
   input wire results_ready_q,
   input wire busy_q
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Hold follows the strobe edge at once, busy one cycle later
   a_strobe_start: assert property (
      $rose(convert_strobe) && !busy_q && !core_power_down_q |=>
      sample_track_q == 8'h00 ##1 busy_q)
      else $error("strobe did not start a conversion");
   a_hold_busy: assert property (busy_q |-> sample_track_q == 8'h00)
      else $error("tracking during conversion");
   a_dac_single: assert property (dac_active_q |-> busy_q)
      else $error("dac active while idle");
   a_search_half: assert property (
      $rose(dac_active_q) |->
      ##[0:3] charge_redistribution_dac_q == {1'b1, {(W-1){1'b0}}})
      else $error("search did not start at half scale");
   a_prep_after: assert property (
      results_ready_q |-> !dac_active_q && !$past(dac_active_q, 4))
      else $error("results ready during conversion");
   a_ready_pulse: assert property (
      results_ready_q |=> !results_ready_q)
      else $error("results ready longer than a cycle");
   a_lvds_lanes: assert property (
      lvds_mode && $past(lvds_mode) |-> output_lanes_q == 4'h1)
      else $error("lanes not one in differential mode");
   a_lane_range: assert property (
      output_lanes_q >= 4'h1 && output_lanes_q <= 4'h8)
      else $error("lane count out of range");
   a_pd_idle: assert property (core_power_down_q |-> !busy_q)
      else $error("power down while converting");
   a_apb_answer: assert property ($rose(penable) && psel |=>
      pready ##1 !pready)
      else $error("apb answer timing");
   a_rd_idle: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
      else $error("read data outside access");
   c_results: cover property (results_ready_q);
   c_pd_strobe: cover property ($rose(convert_strobe) && core_power_down_q);
   c_refused: cover property (pslverr);
endmodule
bind octal_sar_conversion_sequencer sar_seq_checker #(.W(W)) chk_inst (
   .pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
   .convert_strobe, .lvds_mode, .sample_track_q,
   .charge_redistribution_dac_q, .dac_active_q, .core_power_down_q,
   .output_lanes_q, .results_ready_q, .busy_q);

// [tb/tb.sv]
// Self-checking bench: APB master, strobe driver, reference model.
// Assumes the sequencer and analog_core_model compiled before it.
`timescale 1ns/1ps
module tb;
   reg pclk, presetn, psel, penable, pwrite, convert_strobe, lvds_mode;
   reg [11:0] paddr;
   reg [31:0] pwdata, rd, lfsr_q;
   reg [143:0] sample_in;
   reg [17:0] raw [0:7];
   reg err;
   wire [31:0] prdata;
   wire pready, pslverr, comparator_high, dac_active_q;
   wire core_power_down_q, results_ready_q, busy_q;
   wire [7:0] sample_track_q;
   wire [17:0] charge_redistribution_dac_q;
   wire [2:0] dac_channel_q;
   wire [3:0] output_lanes_q;
   integer failures, samples_checked, cc;
   octal_sar_conversion_sequencer octal_sar_conversion_sequencer_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .convert_strobe(convert_strobe),
      .comparator_high(comparator_high), .lvds_mode(lvds_mode),
      .sample_track_q(sample_track_q),
      .charge_redistribution_dac_q(charge_redistribution_dac_q),
      .dac_channel_q(dac_channel_q), .dac_active_q(dac_active_q),
      .core_power_down_q(core_power_down_q),
      .output_lanes_q(output_lanes_q), .results_ready_q(results_ready_q),
      .busy_q(busy_q));
   analog_core_model analog_core_model_inst (
      .pclk(pclk), .sample_in(sample_in), .sample_track_q(sample_track_q),
      .charge_redistribution_dac_q(charge_redistribution_dac_q),
      .dac_channel_q(dac_channel_q), .comparator_high(comparator_high));
   always #25 pclk = ~pclk;
   function [31:0] lfsr_next(input [31:0] x);
      lfsr_next = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task test_done;
      begin
         if (failures == 0 && samples_checked > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // Release costs a cycle so strobes never change twice in one step
   // No local limit on the wait; only the watchdog ends a hung access
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         do begin
            @(posedge pclk);
         end while (pready !== 1'b1);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task rdchk(input [11:0] a, input [31:0] exp);
      begin
         apb(1'b0, a, 32'h0000_0000);
         chk(rd, exp);
      end
   endtask
   task conv(input [23:0] span);
      integer n, c, nen;
      reg [2:0] f;
      begin
         apb(1'b1, 12'h004, {8'h00, span});
         nen = 0;
         for (c = 0; c < 8; c = c + 1) begin
            lfsr_q = lfsr_next(lfsr_q);
            raw[c] = lfsr_q[17:0];
            sample_in[18*c +: 18] <= lfsr_q[17:0];
            if (span[3*c +: 3] != 3'h0) nen = nen + 1;
         end
         convert_strobe <= 1'b1;
         @(posedge pclk);
         convert_strobe <= 1'b0;
         cc = cc + 1;
         n = 0;
         while (results_ready_q !== 1'b1 && n < 2000) begin
            @(posedge pclk);
            n = n + 1;
            if (n == 5) sample_in <= ~sample_in;
            if (n == 20) convert_strobe <= 1'b1;
            if (n == 21) convert_strobe <= 1'b0;
         end
         chk({31'h0, n >= nen * 73 && n <= nen * 73 + 16}, 1);
         repeat (2) @(posedge pclk);
         for (c = 0; c < 8; c = c + 1) begin
            f = span[3*c +: 3];
            rdchk(12'h020 + c * 4, {14'h0, f == 3'h0 ? 18'h0_0000 :
               f[1] ? raw[c] ^ 18'h2_0000 : raw[c]});
         end
         rdchk(12'h00c, {8'h00, span});
         rdchk(12'h010, cc);
         rdchk(12'h008, 32'h0000_0082);
         apb(1'b1, 12'h008, 32'h0000_0002);
         rdchk(12'h008, 32'h0000_0080);
      end
   endtask
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      convert_strobe = 1'b0;
      lvds_mode = 1'b0;
      sample_in = 144'h0;
      failures = 0;
      samples_checked = 0;
      cc = 0;
      lfsr_q = 32'h0000_3460;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk(12'h000, 32'h0000_0000);
      rdchk(12'h004, 32'h00ff_ffff);
      rdchk(12'h008, 32'h0000_0010);
      rdchk(12'h100, 32'h0000_0000);
      chk({31'h0, err}, 1);
      apb(1'b1, 12'h000, 32'h0000_000e);
      // Lane count is registered one cycle after the control word lands
      @(posedge pclk);
      chk({28'h0, output_lanes_q}, 8);
      lvds_mode <= 1'b1;
      repeat (2) @(posedge pclk);
      chk({28'h0, output_lanes_q}, 1);
      rdchk(12'h008, 32'h0000_0014);
      lvds_mode <= 1'b0;
      conv(24'hfa_c688);
      conv(24'hff_ffff);
      conv(24'h00_0007);
      lfsr_q = lfsr_next(lfsr_q);
      conv(lfsr_q[23:0] | 24'h00_0007);
      apb(1'b1, 12'h000, 32'h0000_000f);
      @(posedge pclk);
      chk({31'h0, core_power_down_q}, 1);
      convert_strobe <= 1'b1;
      @(posedge pclk);
      convert_strobe <= 1'b0;
      repeat (10) @(posedge pclk);
      chk({31'h0, busy_q}, 0);
      rdchk(12'h010, cc);
      rdchk(12'h008, 32'h0000_0088);
      apb(1'b1, 12'h000, 32'h0000_000e);
      conv(24'h00_0e00);
      test_done;
   end
   initial begin
      #(20_000 * 50);
      failures = failures + 1;
      test_done;
   end
endmodule
